// file: core/pmt_mem.sv
// Flash array model: 24-bit words, registered read data
`timescale 1ns/1ps
module pmt_mem (
  // Clock
  input  wire logic                  mclk_i,
  // Access
  input  wire pmt_pkg::pmt_mem_req_t req_i,
  output logic [23:0]                rdata_o
);

  logic [23:0] mem_array [0:4095];

  // ------------------------------------------------------------
  // Array port
  // ------------------------------------------------------------
  // Read returns the old word on a write cycle
  always_ff @(posedge mclk_i) begin
    if (req_i.we) begin
      mem_array[req_i.idx] <= req_i.wdata;
    end
    rdata_o <= mem_array[req_i.idx];
  end

endmodule : pmt_mem

// file: core/pmt_top.sv
// Program memory table access and self-programming control, APB slave
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "pmt_defs.svh"

// How it works
// - 24-bit program words, 16-bit data words
// - Address is page byte over effective address
// - Page top bit selects configuration space
// - Program word index ignores address bit zero
// - Table addresses need no alignment
// - Word low read returns bits 15..0
// - Byte low read picks byte by select
// - Word high read returns bits 23..16, zero-extended
// - Byte high read zero when select set
// - Low ops bits 15..0, high 23..16
// - Two byte addresses per program word
// - Window is read-only, low word only
// - Erase clears one 1024-word page
// - Program writes exactly two words
// - Stall while erase or program runs
// - Go bit starts, hardware clears at end
// - Code 0011 erases, 0001 programs
// - Operations only while enable bit set
// - Bad start sets sequence error flag
module pmt_top (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Core status
  output logic             stall_o,
  output logic             cfg_space_o
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Assert at once, release after two edges
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pmt_pkg::pmt_state_t   state_reg;
  pmt_pkg::pmt_key_t     key_reg;
  pmt_pkg::pmt_mem_req_t mem_req;
  logic [9:0]            cnt_reg;
  logic                  go_reg;
  logic                  en_reg;
  logic                  err_reg;
  logic [3:0]            op_reg;
  logic [7:0]            page_reg;
  logic [15:0]           ea_reg;
  logic [15:0]           data_reg;
  logic [23:0]           nadr_reg;
  logic [23:0]           latch_reg [0:1];
  logic                  mem_wait_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [31:0]           prdata_reg;
  logic                  stall_reg;
  logic                  cfg_reg;
  logic [23:0]           mem_rdata;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire busy     = (state_reg != pmt_pkg::ST_IDLE);
  wire acc      = psel_i & penable_i & ~pready_reg;
  wire hit_ctrl = (paddr_i == `PMT_OFS_CTRL);
  wire hit_key  = (paddr_i == `PMT_OFS_KEY);
  wire hit_page = (paddr_i == `PMT_OFS_PAGE);
  wire hit_ea   = (paddr_i == `PMT_OFS_EA);
  wire hit_cmd  = (paddr_i == `PMT_OFS_CMD);
  wire hit_data = (paddr_i == `PMT_OFS_DATA);
  wire hit_nadr = (paddr_i == `PMT_OFS_NADR);
  wire hit_psv  = (paddr_i == `PMT_OFS_PSV);
  wire mapped   = hit_ctrl | hit_key | hit_page | hit_ea | hit_cmd | hit_data
                | hit_nadr | hit_psv;
  wire cmd_high = pwdata_i[`PMT_CMD_HIGH];
  wire cmd_wr   = pwdata_i[`PMT_CMD_WRITE];
  wire cmd_byte = pwdata_i[`PMT_CMD_BYTE];
  // Accesses that must wait one cycle for array read data
  wire need_mem = (hit_cmd & pwrite_i & ~cmd_wr) | (hit_psv & ~pwrite_i);
  // The core is held on the bus too while the array is busy
  wire done_now = acc & ~busy & (~need_mem | mem_wait_reg);
  wire commit   = done_now & pwrite_i;
  wire psv_wr   = hit_psv & pwrite_i;

  // ------------------------------------------------------------
  // Table address
  // ------------------------------------------------------------
  wire [23:0] prog_addr = {page_reg, ea_reg};
  wire        bsel      = prog_addr[0];
  // One program word per pair of byte addresses
  wire [11:0] tbl_idx   = {prog_addr[23], prog_addr[11:1]};
  wire        tbl_rd    = commit & hit_cmd & ~cmd_wr;
  wire        tbl_wr    = commit & hit_cmd & cmd_wr;
  wire        lat_sel   = prog_addr[1];

  // ------------------------------------------------------------
  // Table read formatting
  // ------------------------------------------------------------
  wire [7:0]  low_byte  = bsel ? mem_rdata[15:8] : mem_rdata[7:0];
  wire [15:0] rd_low    = cmd_byte ? {8'h00, low_byte} : mem_rdata[15:0];
  wire [15:0] rd_high   = (cmd_byte && bsel) ? 16'h0000
                        : {8'h00, mem_rdata[23:16]};
  wire [15:0] rd_fmt    = cmd_high ? rd_high : rd_low;

  // ------------------------------------------------------------
  // Holding latch merge
  // ------------------------------------------------------------
  // Byte writes to the phantom upper byte leave the latch alone
  function automatic logic [23:0] latch_merge(input logic [23:0] old,
                                              input logic [15:0] d,
                                              input logic        high,
                                              input logic        bytes,
                                              input logic        bs);
    logic [23:0] res;
    res = old;
    if (high) begin
      if (!(bytes && bs)) begin
        res[23:16] = d[7:0];
      end
    end else if (!bytes) begin
      res[15:0] = d;
    end else if (bs) begin
      res[15:8] = d[7:0];
    end else begin
      res[7:0] = d[7:0];
    end
    return res;
  endfunction : latch_merge

  // One latch per word of the programmed pair
  for (genvar gi = 0; gi < 2; gi++) begin : g_latch
    always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
        latch_reg[gi] <= `PMT_ERASED;
      end else if (tbl_wr && (lat_sel == 1'(gi))) begin
        latch_reg[gi] <= latch_merge(latch_reg[gi], data_reg, cmd_high,
                                     cmd_byte, bsel);
      end
    end
  end

  // ------------------------------------------------------------
  // Unlock and start decision
  // ------------------------------------------------------------
  wire [7:0] key_val  = pwdata_i[7:0];
  wire       go_req   = commit & hit_ctrl & pwdata_i[`PMT_CTRL_GO] & ~go_reg;
  wire       op_erase = (pwdata_i[3:0] == `PMT_OP_ERASE);
  wire       op_prog  = (pwdata_i[3:0] == `PMT_OP_PROG);
  // Only a fully unlocked, enabled, valid request starts the array
  wire       start_ok = go_req & (key_reg == pmt_pkg::KEY_OPEN)
                      & pwdata_i[`PMT_CTRL_EN]
                      & (op_erase | op_prog);
  wire       err_set  = go_req & ~start_ok;
  wire       op_done  = ((state_reg == pmt_pkg::ST_ERASE) && (cnt_reg == `PMT_PAGE_LAST))
                      | ((state_reg == pmt_pkg::ST_PROG) && cnt_reg[0]);

  // Any write other than the first or second key voids a half unlock
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      key_reg <= pmt_pkg::KEY_NONE;
    end else if (commit) begin
      if (hit_key && key_val == `PMT_KEY_FIRST) begin
        key_reg <= pmt_pkg::KEY_HALF;
      end else if (hit_key && key_val == `PMT_KEY_SECOND
                   && key_reg == pmt_pkg::KEY_HALF) begin
        key_reg <= pmt_pkg::KEY_OPEN;
      end else begin
        key_reg <= pmt_pkg::KEY_NONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Error set wins over a software clear in the same write
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      go_reg  <= 1'b0;
      en_reg  <= 1'b0;
      err_reg <= 1'b0;
      op_reg  <= `PMT_RST_OP;
    end else begin
      if (commit && hit_ctrl) begin
        en_reg <= pwdata_i[`PMT_CTRL_EN];
        op_reg <= pwdata_i[3:0];
      end
      if (err_set) begin
        err_reg <= 1'b1;
      end else if (commit && hit_ctrl) begin
        err_reg <= pwdata_i[`PMT_CTRL_ERR];
      end
      if (start_ok) begin
        go_reg <= 1'b1;
      end else if (op_done) begin
        go_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Address and data registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `PMT_RST_PAGE;
      ea_reg   <= `PMT_RST_EA;
      nadr_reg <= `PMT_RST_NADR;
      data_reg <= 16'h0000;
      cfg_reg  <= 1'b0;
    end else begin
      if (commit && hit_page) page_reg <= pwdata_i[7:0];
      if (commit && hit_ea)   ea_reg   <= pwdata_i[15:0];
      if (commit && hit_nadr) nadr_reg <= pwdata_i[23:0];
      if (tbl_rd) begin
        data_reg <= rd_fmt;
      end else if (commit && hit_data) begin
        data_reg <= pwdata_i[15:0];
      end
      if (commit && hit_cmd) cfg_reg <= page_reg[7];
    end
  end

  // ------------------------------------------------------------
  // Erase and program sequencer
  // ------------------------------------------------------------
  // Self-timed by the number of array writes, one per cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pmt_pkg::ST_IDLE;
      cnt_reg   <= 10'h000;
    end else begin
      case (state_reg)
        pmt_pkg::ST_IDLE: begin
          cnt_reg <= 10'h000;
          if (start_ok) begin
            state_reg <= op_erase ? pmt_pkg::ST_ERASE : pmt_pkg::ST_PROG;
          end
        end
        pmt_pkg::ST_ERASE, pmt_pkg::ST_PROG: begin
          cnt_reg <= cnt_reg + 10'h001;
          if (op_done) state_reg <= pmt_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= pmt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Array port: sequencer writes, otherwise table and window reads
  wire [11:0] erase_idx = {nadr_reg[23], nadr_reg[11], cnt_reg};
  wire [11:0] prog_idx  = {nadr_reg[23], nadr_reg[11:2], cnt_reg[0]};
  assign mem_req.we    = busy;
  assign mem_req.idx   = (state_reg == pmt_pkg::ST_ERASE) ? erase_idx
                       : busy ? prog_idx : tbl_idx;
  assign mem_req.wdata = (state_reg == pmt_pkg::ST_ERASE) ? `PMT_ERASED
                       : latch_reg[cnt_reg[0]];

  pmt_mem u_mem (
    .mclk_i  (mclk_i),
    .req_i   (mem_req),
    .rdata_o (mem_rdata)
  );

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire [31:0] ctrl_view = {16'h0000, go_reg, en_reg, err_reg, 9'h000, op_reg};
  wire [31:0] rd_mux    = hit_ctrl ? ctrl_view
                        : hit_page ? {24'h000000, page_reg}
                        : hit_ea   ? {16'h0000, ea_reg}
                        : hit_data ? {16'h0000, data_reg}
                        : hit_nadr ? {8'h00, nadr_reg}
                        : hit_psv  ? {16'h0000, mem_rdata[15:0]}
                        : 32'h00000000;

  // ------------------------------------------------------------
  // Bus answer and status outputs
  // ------------------------------------------------------------
  // Answer is one pulse; unmapped and window writes report an error
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_wait_reg <= 1'b0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h00000000;
      stall_reg    <= 1'b0;
    end else begin
      mem_wait_reg <= acc & ~busy & need_mem & ~mem_wait_reg;
      pready_reg   <= done_now;
      pslverr_reg  <= done_now & (~mapped | psv_wr);
      if (done_now && !pwrite_i) prdata_reg <= rd_mux;
      stall_reg    <= start_ok | (busy & ~op_done);
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign stall_o     = stall_reg;
  assign cfg_space_o = cfg_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  property p_go_start;
    start_ok |=> go_reg && stall_o && busy;
  endproperty
  a_go_start: assert property (p_go_start) else $error("start missed");

  property p_prog_two;
    start_ok && op_prog |=> mem_req.we ##1 mem_req.we ##1 !busy && !go_reg;
  endproperty
  a_prog_two: assert property (p_prog_two) else $error("bad program length");

  property p_erase_fill;
    state_reg == pmt_pkg::ST_ERASE |-> mem_req.wdata == `PMT_ERASED
                                       && mem_req.idx[9:0] == cnt_reg;
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("bad erase write");

  property p_locked_err;
    go_req && key_reg != pmt_pkg::KEY_OPEN |=> err_reg && !busy;
  endproperty
  a_locked_err: assert property (p_locked_err) else $error("locked start");

  property p_disabled;
    go_req && !pwdata_i[`PMT_CTRL_EN] |=> !busy ##1 !busy;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled start");

  property p_high_phantom;
    tbl_rd && cmd_high && !cmd_byte |=> data_reg[15:8] == 8'h00;
  endproperty
  a_high_phantom: assert property (p_high_phantom) else $error("phantom set");

  property p_psv_ro;
    done_now && psv_wr |=> pready_o && pslverr_o;
  endproperty
  a_psv_ro: assert property (p_psv_ro) else $error("window write taken");

  property p_array_guard;
    mem_req.we |-> go_reg && stall_o;
  endproperty
  a_array_guard: assert property (p_array_guard) else $error("stray array write");

  c_erase: cover property (start_ok && op_erase);
  c_prog: cover property (start_ok && op_prog);
  c_tbl_rd: cover property (tbl_rd ##1 pready_o);

endmodule : pmt_top

// file: inc/pmt_defs.svh
// Register offsets, field positions, reset values and counts of the table access block
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMT_OFS_CTRL   8'h00
`define PMT_OFS_KEY    8'h04
`define PMT_OFS_PAGE   8'h08
`define PMT_OFS_EA     8'h0C
`define PMT_OFS_CMD    8'h10
`define PMT_OFS_DATA   8'h14
`define PMT_OFS_NADR   8'h18
`define PMT_OFS_PSV    8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMT_CTRL_GO    15
`define PMT_CTRL_EN    14
`define PMT_CTRL_ERR   13
`define PMT_CMD_HIGH   0
`define PMT_CMD_WRITE  1
`define PMT_CMD_BYTE   2

// ----------------------------------------------------------------
// Codes, keys and counts
// ----------------------------------------------------------------
`define PMT_OP_ERASE   4'h3
`define PMT_OP_PROG    4'h1
`define PMT_KEY_FIRST  8'h55
`define PMT_KEY_SECOND 8'hAA
`define PMT_PAGE_LAST  10'h3FF
`define PMT_ERASED     24'hFFFFFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMT_RST_OP     4'h0
`define PMT_RST_PAGE   8'h00
`define PMT_RST_EA     16'h0000
`define PMT_RST_NADR   24'h000000

`endif

// file: inc/pmt_pkg.sv
// Types shared by the table access block and its flash array
package pmt_pkg;

  // Flash operation sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} pmt_state_t;

  // Unlock progress
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OPEN} pmt_key_t;

  // One access to the flash array
  typedef struct packed {
    logic        we;
    logic [11:0] idx;
    logic [23:0] wdata;
  } pmt_mem_req_t;

endpackage : pmt_pkg

// file: verification/pmt_core_model.sv
// Processor core model: APB master issuing register, table and flash commands
`timescale 1ns/1ps
`include "pmt_defs.svh"
module pmt_core_model (
  // Clock
  input  wire logic        mclk_i,
  // APB master side
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  logic [31:0] rd_q;
  logic        err_q;

  // ----------------------------------------------------------------
  // Bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
    rd_q      = 32'h0000_0000;
    err_q     = 1'b0;
  end

  // One transfer, entered just after a rising edge; only the bench timeout ends the wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    do @(posedge mclk_i); while (pready_i !== 1'b1);
    rd_q  = prdata_i;
    err_q = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // Idle cycle so the next setup never lands in the release time step
    @(posedge mclk_i);
  endtask : xfer

  // Full unlock then start; a core stalls on its next access until the operation ends
  task automatic unlock_start(input logic [31:0] ctrl);
    xfer(1'b1, `PMT_OFS_KEY, {24'h000000, `PMT_KEY_FIRST});
    xfer(1'b1, `PMT_OFS_KEY, {24'h000000, `PMT_KEY_SECOND});
    xfer(1'b1, `PMT_OFS_CTRL, ctrl);
  endtask : unlock_start
endmodule : pmt_core_model

// file: verification/program_memory_table_access_tb.sv
// Self-checking bench of the table access block driven by the core model
`timescale 1ns/1ps
`include "pmt_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module program_memory_table_access_tb;
  logic        mclk_i;
  logic        rst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stall_o;
  logic        cfg_space_o;
  int          errors;
  int          tests_run;
  int          cycles;
  int          stall_cnt;

  pmt_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .stall_o(stall_o), .cfg_space_o(cfg_space_o));
  pmt_core_model i_core (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  // ----------------------------------------------------------------
  // Clock, stall counter and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Stall length is counted so erase and program durations can be bounded
  always @(posedge mclk_i) begin
    cycles++;
    if (stall_o === 1'b1) stall_cnt++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_core.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_core.xfer(1'b0, a, 32'h0000_0000);
    `CHK(i_core.rd_q, e)
    `CHK(i_core.err_q, 1'b0)
  endtask : rd_chk

  // Table command at {page, ea}; reads return through the data register
  task automatic tread(input logic [7:0] pg, input logic [15:0] ea, input logic [2:0] cmd,
                       input logic [15:0] e);
    wr(`PMT_OFS_PAGE, {24'h000000, pg});
    wr(`PMT_OFS_EA, {16'h0000, ea});
    wr(`PMT_OFS_CMD, {29'h00000000, cmd});
    rd_chk(`PMT_OFS_DATA, {16'h0000, e});
  endtask : tread

  task automatic twrite(input logic [15:0] ea, input logic [2:0] cmd, input logic [15:0] d);
    wr(`PMT_OFS_DATA, {16'h0000, d});
    wr(`PMT_OFS_PAGE, 32'h0000_0000);
    wr(`PMT_OFS_EA, {16'h0000, ea});
    wr(`PMT_OFS_CMD, {29'h00000000, cmd});
  endtask : twrite

  // Unlocked start; go must read back cleared, with stall length inside the bounds
  task automatic flash_op(input logic [23:0] na, input logic [3:0] op, input int lo, input int hi);
    wr(`PMT_OFS_NADR, {8'h00, na});
    stall_cnt = 0;
    i_core.unlock_start({16'h0000, 12'hC00, op});
    rd_chk(`PMT_OFS_CTRL, {16'h0000, 12'h400, op});
    `CHK(stall_cnt >= lo && stall_cnt <= hi, 1'b1)
  endtask : flash_op

  // Refused start: keys 0 none, 2 both, 3 both with a page write between them
  task automatic bad_start(input int keys, input logic [31:0] ctrl);
    stall_cnt = 0;
    if (keys > 0) wr(`PMT_OFS_KEY, {24'h000000, `PMT_KEY_FIRST});
    if (keys == 3) wr(`PMT_OFS_PAGE, 32'h0000_0000);
    if (keys > 0) wr(`PMT_OFS_KEY, {24'h000000, `PMT_KEY_SECOND});
    wr(`PMT_OFS_CTRL, ctrl);
    rd_chk(`PMT_OFS_CTRL, (ctrl & 32'h0000_400F) | 32'h0000_2000);
    `CHK(stall_cnt, 0)
    wr(`PMT_OFS_CTRL, 32'h0000_0000);
  endtask : bad_start

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors    = 0;
    tests_run = 0;
    cycles    = 0;
    stall_cnt = 0;
    rst_n_i   = 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    // Reset state and an unmapped address
    rd_chk(`PMT_OFS_CTRL, 32'h0000_0000);
    rd_chk(`PMT_OFS_PAGE, 32'h0000_0000);
    rd_chk(`PMT_OFS_NADR, 32'h0000_0000);
    i_core.xfer(1'b0, 8'h20, 32'h0000_0000);
    `CHK(i_core.err_q, 1'b1)
    // Erase user page, check the far corner
    flash_op(24'h000000, `PMT_OP_ERASE, 1024, 1026);
    tread(8'h00, 16'h07FE, 3'h0, 16'hFFFF);
    tread(8'h00, 16'h07FE, 3'h1, 16'h00FF);
    // Stage a word pair; the array stays erased until programmed
    twrite(16'h0000, 3'h2, 16'hA55A);
    twrite(16'h0000, 3'h3, 16'h0012);
    twrite(16'h0002, 3'h2, 16'hBEEF);
    twrite(16'h0002, 3'h3, 16'h0034);
    tread(8'h00, 16'h0000, 3'h0, 16'hFFFF);
    flash_op(24'h000000, `PMT_OP_PROG, 2, 4);
    tread(8'h00, 16'h0000, 3'h0, 16'hA55A);
    tread(8'h00, 16'h0000, 3'h4, 16'h005A);
    tread(8'h00, 16'h0001, 3'h4, 16'h00A5);
    tread(8'h00, 16'h0000, 3'h1, 16'h0012);
    tread(8'h00, 16'h0000, 3'h5, 16'h0012);
    tread(8'h00, 16'h0001, 3'h5, 16'h0000);
    tread(8'h00, 16'h0003, 3'h0, 16'hBEEF);
    tread(8'h00, 16'h0002, 3'h1, 16'h0034);
    tread(8'h00, 16'h0004, 3'h0, 16'hFFFF);
    // Read-only window shows the low word only
    wr(`PMT_OFS_EA, 32'h0000_0002);
    rd_chk(`PMT_OFS_PSV, 32'h0000_BEEF);
    i_core.xfer(1'b1, `PMT_OFS_PSV, 32'h0000_1111);
    `CHK(i_core.err_q, 1'b1)
    rd_chk(`PMT_OFS_PSV, 32'h0000_BEEF);
    // Configuration space is separate from user space
    flash_op(24'h800000, `PMT_OP_ERASE, 1024, 1026);
    tread(8'h80, 16'h0000, 3'h0, 16'hFFFF);
    `CHK(cfg_space_o, 1'b1)
    tread(8'h00, 16'h0000, 3'h0, 16'hA55A);
    `CHK(cfg_space_o, 1'b0)
    // Refused starts never stall and raise the error flag
    bad_start(0, 32'h0000_C001);
    bad_start(2, 32'h0000_8001);
    bad_start(3, 32'h0000_C001);
    for (int c = 0; c < 16; c++) begin
      if (c != 1 && c != 3) bad_start(2, {16'h0000, 12'hC00, c[3:0]});
    end
    rd_chk(`PMT_OFS_CTRL, 32'h0000_0000);
    tread(8'h00, 16'h0004, 3'h0, 16'hFFFF);
    // Byte writes into latch 0; the phantom byte write is dropped
    twrite(16'h0001, 3'h6, 16'h0077);
    twrite(16'h0000, 3'h6, 16'h0033);
    twrite(16'h0001, 3'h7, 16'h0099);
    twrite(16'h0000, 3'h7, 16'h0056);
    flash_op(24'h000004, `PMT_OP_PROG, 2, 4);
    tread(8'h00, 16'h0004, 3'h0, 16'h7733);
    tread(8'h00, 16'h0004, 3'h1, 16'h0056);
    tread(8'h00, 16'h0006, 3'h0, 16'hBEEF);
    test_done();
  end
endmodule : program_memory_table_access_tb
